// ==== plc_cells.sv ====
// Two programmable lookup-table logic cells with their register port
`timescale 1ns/1ps

module plc_cells
   import plc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [3:0] io_pin_i,
   input wire logic [3:0] soft_bit_i,
   input wire logic cnt_zero_begin_evt_i,
   input wire logic cnt_one_begin_evt_i,
   input wire logic cnt_zero_finish_evt_i,
   input wire logic cnt_one_finish_evt_i,
   input wire logic expose_begin_evt_i,
   input wire logic expose_finish_evt_i,
   input wire logic awaiting_frame_trig_i,
   input wire logic capture_running_i,
   output logic cell_zero_out_o,
   output logic cell_one_out_o
);

   // ************************************************************
   // Functions
   // ************************************************************

   // Qualify one source bit by level or by edge
   function automatic logic qualify(
      input logic [4:0] sel,
      input logic [2:0] qual,
      input logic [PLC_NSRC-1:0] cur,
      input logic [PLC_NSRC-1:0] prev
   );
      logic c;
      logic p;
      c = 1'b0;
      p = 1'b0;
      if (sel <= PLC_SRC_LAST) begin
         c = cur[sel];
         p = prev[sel];
      end
      case (qual)
         PLC_QUAL_LOW_LEVEL: qualify = ~c;
         PLC_QUAL_HIGH_LEVEL: qualify = c;
         PLC_QUAL_FALL: qualify = p & ~c;
         PLC_QUAL_RISE: qualify = c & ~p;
         PLC_QUAL_EITHER_TRANSITION: qualify = c ^ p;
         default: qualify = 1'b0;
      endcase
   endfunction

   // Pick one of a cell's two tables
   function automatic logic [7:0] pick_tab(
      input logic tsel,
      input logic [7:0] vtab,
      input logic [7:0] etab
   );
      pick_tab = tsel ? etab : vtab;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   logic cell_sel_q;
   logic table_sel_q;
   logic [1:0] in_sel_q;
   logic [2:0] row_q;
   logic [4:0] src_sel_q [PLC_NCELL][PLC_NIN];
   logic [2:0] qual_q [PLC_NCELL][PLC_NIN];
   logic [7:0] vtab_q [PLC_NCELL];
   logic [7:0] etab_q [PLC_NCELL];
   logic [PLC_NCELL-1:0] cell_q;
   logic [PLC_NSRC-1:0] src_q;
   logic [PLC_NSRC-1:0] src_prev_q;
   logic [7:0] rdata_q;

   // ************************************************************
   // Register decode
   // ************************************************************
   logic wr_cell, wr_tsel, wr_isel, wr_src, wr_qual;
   logic wr_word, wr_row, wr_bit;
   logic [7:0] cur_tab_w;
   logic [7:0] new_tab_w;
   logic [7:0] rdata_d;

   // Write strobes per register
   assign wr_cell = reg_wr_i && reg_addr_i == PLC_OFS_CELL_SEL;
   assign wr_tsel = reg_wr_i && reg_addr_i == PLC_OFS_TABLE_SEL;
   assign wr_isel = reg_wr_i && reg_addr_i == PLC_OFS_INPUT_SEL;
   assign wr_src = reg_wr_i && reg_addr_i == PLC_OFS_INPUT_SRC;
   assign wr_qual = reg_wr_i && reg_addr_i == PLC_OFS_INPUT_QUAL;
   assign wr_word = reg_wr_i && reg_addr_i == PLC_OFS_TT_WORD;
   assign wr_row = reg_wr_i && reg_addr_i == PLC_OFS_ROW_INDEX;
   assign wr_bit = reg_wr_i && reg_addr_i == PLC_OFS_ROW_BIT;

   // Table addressed by cell and table selectors
   assign cur_tab_w = pick_tab(table_sel_q, vtab_q[cell_sel_q],
                               etab_q[cell_sel_q]);

   // Whole word replaces, row bit patches a single position
   assign new_tab_w = wr_word ? reg_wdata_i :
      (cur_tab_w & ~(8'h01 << row_q)) |
      ({7'h00, reg_wdata_i[0]} << row_q);

   // Read mux; unmapped offsets answer zero
   always_comb begin
      rdata_d = 8'h00;
      if (!reg_rd_i) begin
         rdata_d = 8'h00;
      end else if (reg_addr_i == PLC_OFS_CELL_SEL) begin
         rdata_d = {7'h00, cell_sel_q};
      end else if (reg_addr_i == PLC_OFS_TABLE_SEL) begin
         rdata_d = {7'h00, table_sel_q};
      end else if (reg_addr_i == PLC_OFS_INPUT_SEL) begin
         rdata_d = {6'h00, in_sel_q};
      end else if (reg_addr_i == PLC_OFS_INPUT_SRC) begin
         rdata_d = {3'h0, src_sel_q[cell_sel_q][in_sel_q]};
      end else if (reg_addr_i == PLC_OFS_INPUT_QUAL) begin
         rdata_d = {5'h00, qual_q[cell_sel_q][in_sel_q]};
      end else if (reg_addr_i == PLC_OFS_TT_WORD) begin
         rdata_d = cur_tab_w;
      end else if (reg_addr_i == PLC_OFS_ROW_INDEX) begin
         rdata_d = {5'h00, row_q};
      end else if (reg_addr_i == PLC_OFS_ROW_BIT) begin
         rdata_d = {7'h00, cur_tab_w[row_q]};
      end else if (reg_addr_i == PLC_OFS_STATUS) begin
         rdata_d = {6'h00, cell_q};
      end
   end

   // ************************************************************
   // Selectors and read data
   // ************************************************************

   // Selectors steer every later configuration access
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cell_sel_q <= 1'b0;
         table_sel_q <= 1'b0;
         in_sel_q <= 2'h0;
         row_q <= 3'h0;
         rdata_q <= PLC_RST_RDATA;
      end else begin
         if (wr_cell) cell_sel_q <= reg_wdata_i[0];
         if (wr_tsel) table_sel_q <= reg_wdata_i[0];
         if (wr_isel) in_sel_q <= reg_wdata_i[1:0];
         if (wr_row) row_q <= reg_wdata_i[2:0];
         rdata_q <= rdata_d;
      end
   end

   // ************************************************************
   // Per-cell configuration
   // ************************************************************

   // One input set per cell serves both tables
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int c = 0; c < PLC_NCELL; c++) begin
            vtab_q[c] <= PLC_RST_TAB;
            etab_q[c] <= PLC_RST_TAB;
            for (int i = 0; i < PLC_NIN; i++) begin
               src_sel_q[c][i] <= PLC_RST_SRC;
               qual_q[c][i] <= PLC_RST_QUAL;
            end
         end
      end else begin
         if (wr_src) begin
            src_sel_q[cell_sel_q][in_sel_q] <= reg_wdata_i[4:0];
         end
         if (wr_qual) begin
            qual_q[cell_sel_q][in_sel_q] <= reg_wdata_i[2:0];
         end
         if ((wr_word || wr_bit) && table_sel_q) begin
            etab_q[cell_sel_q] <= new_tab_w;
         end
         if ((wr_word || wr_bit) && !table_sel_q) begin
            vtab_q[cell_sel_q] <= new_tab_w;
         end
      end
   end

   // ************************************************************
   // Source capture
   // ************************************************************
   logic [PLC_NSRC-1:0] src_raw;

   // Bit position equals the source code; code zero is constant zero
   assign src_raw = {capture_running_i, awaiting_frame_trig_i,
                     expose_finish_evt_i, expose_begin_evt_i,
                     cell_q[1], cell_q[0],
                     cnt_one_finish_evt_i, cnt_zero_finish_evt_i,
                     cnt_one_begin_evt_i, cnt_zero_begin_evt_i,
                     soft_bit_i, io_pin_i, 1'b0};

   // Two registered copies give a one-cycle edge pulse
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         src_q <= '0;
         src_prev_q <= '0;
      end else begin
         src_q <= src_raw;
         src_prev_q <= src_q;
      end
   end

   // ************************************************************
   // Lookup and output flip-flops
   // ************************************************************
   logic [2:0] row_idx [PLC_NCELL];
   logic [PLC_NCELL-1:0] val_w;
   logic [PLC_NCELL-1:0] en_w;

   // Slot 3 is stored but only slots 0..2 address the tables
   for (genvar c = 0; c < PLC_NCELL; c++) begin : g_cell
      for (genvar i = 0; i < 3; i++) begin : g_in
         assign row_idx[c][i] = qualify(src_sel_q[c][i], qual_q[c][i],
                                        src_q, src_prev_q);
      end
      assign val_w[c] = vtab_q[c][row_idx[c]];
      assign en_w[c] = etab_q[c][row_idx[c]];
   end

   // Enable gates the load, otherwise the output holds
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cell_q <= '0;
      end else begin
         for (int c = 0; c < PLC_NCELL; c++) begin
            if (en_w[c]) cell_q[c] <= val_w[c];
         end
      end
   end

   assign cell_zero_out_o = cell_q[0];
   assign cell_one_out_o = cell_q[1];
   assign reg_rdata_o = rdata_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);

   property p_hold_when_disabled;
      !en_w[0] |=> $stable(cell_q[0]);
   endproperty
   a_hold_when_disabled: assert property (p_hold_when_disabled)
      else $error("cell output changed while enable low");

   property p_load_when_enabled;
      en_w[1] |=> cell_q[1] == $past(val_w[1]);
   endproperty
   a_load_when_enabled: assert property (p_load_when_enabled)
      else $error("cell output missed value table");

   property p_follow_all_ones;
      etab_q[0] == 8'hff |=> cell_q[0] == $past(val_w[0]);
   endproperty
   a_follow_all_ones: assert property (p_follow_all_ones)
      else $error("transparent cell did not follow");

   property p_word_loads;
      wr_word |=> cur_tab_w == $past(reg_wdata_i);
   endproperty
   a_word_loads: assert property (p_word_loads)
      else $error("whole word write not stored");

   property p_bit_isolated;
      wr_bit |=> ((cur_tab_w ^ $past(cur_tab_w)) &
                  ~(8'h01 << row_q)) == 8'h00 &&
                 cur_tab_w[row_q] == $past(reg_wdata_i[0]);
   endproperty
   a_bit_isolated: assert property (p_bit_isolated)
      else $error("row bit write disturbed other rows");

   property p_cells_independent;
      (wr_word || wr_bit || wr_src) && cell_sel_q |=>
         $stable(vtab_q[0]) && $stable(etab_q[0]) &&
         $stable(src_sel_q[0][0]);
   endproperty
   a_cells_independent: assert property (p_cells_independent)
      else $error("cell one access changed cell zero");

   property p_src_readback;
      wr_src ##1 !wr_src ##1 reg_rd_i && reg_addr_i == PLC_OFS_INPUT_SRC
         && $stable(cell_sel_q) && $stable(in_sel_q)
         |=> reg_rdata_o == {3'h0, $past(reg_wdata_i[4:0], 3)};
   endproperty
   a_src_readback: assert property (p_src_readback)
      else $error("input source read back wrong");

   property p_rise_pulse;
      qual_q[0][0] == PLC_QUAL_RISE && src_sel_q[0][0] == 5'h01 &&
      io_pin_i[0] && !src_q[1] ##1 $stable(qual_q[0][0]) &&
      $stable(src_sel_q[0][0]) ##1 $stable(qual_q[0][0]) &&
      $stable(src_sel_q[0][0])
         |-> $past(row_idx[0][0]) && !row_idx[0][0];
   endproperty
   a_rise_pulse: assert property (p_rise_pulse)
      else $error("rising edge not a one-cycle pulse");

   // Falling edge pulse sits one cycle after the input pin drops, in the first cycle the source register reads low
   property p_fall_pulse;
      qual_q[1][0] == PLC_QUAL_FALL && src_sel_q[1][0] == 5'h03 &&
      !io_pin_i[2] && src_q[3] ##1 $stable(qual_q[1][0]) &&
      $stable(src_sel_q[1][0]) ##1 $stable(qual_q[1][0]) &&
      $stable(src_sel_q[1][0])
         |-> $past(row_idx[1][0]) && !row_idx[1][0];
   endproperty
   a_fall_pulse: assert property (p_fall_pulse)
      else $error("falling edge not a one-cycle pulse");

   // Row index is plain storage, read back at its own offset and used by row bit accesses
   property p_row_index;
      wr_row |=> row_q == $past(reg_wdata_i[2:0]);
   endproperty
   a_row_index: assert property (p_row_index)
      else $error("row index not stored");

   // Enable table selected still lands in the one shared input set
   property p_shared_inputs;
      wr_src && table_sel_q && !cell_sel_q && in_sel_q == 2'h0 |=>
         src_sel_q[0][0] == $past(reg_wdata_i[4:0]);
   endproperty
   a_shared_inputs: assert property (p_shared_inputs)
      else $error("input source not shared by both tables");

endmodule // plc_cells

// ==== plc_pkg.sv ====
// Constants and types shared by the programmable lookup-table logic cells
package plc_pkg;

   // ************************************************************
   // Widths and counts
   // ************************************************************
   localparam int PLC_DW = 8;       // Register data width
   localparam int PLC_AW = 4;       // Register address width
   localparam int PLC_NCELL = 2;    // Logic cells
   localparam int PLC_NIN = 4;      // Input slots per cell
   localparam int PLC_SRC_W = 5;    // Source selector width
   localparam int PLC_NSRC = 19;    // Selectable sources
   localparam int PLC_ROW_W = 3;    // Truth-table row index width

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [3:0] PLC_OFS_CELL_SEL = 4'h0;
   localparam logic [3:0] PLC_OFS_TABLE_SEL = 4'h1;
   localparam logic [3:0] PLC_OFS_INPUT_SEL = 4'h2;
   localparam logic [3:0] PLC_OFS_INPUT_SRC = 4'h3;
   localparam logic [3:0] PLC_OFS_INPUT_QUAL = 4'h4;
   localparam logic [3:0] PLC_OFS_TT_WORD = 4'h5;
   localparam logic [3:0] PLC_OFS_ROW_INDEX = 4'h6;
   localparam logic [3:0] PLC_OFS_ROW_BIT = 4'h7;
   localparam logic [3:0] PLC_OFS_STATUS = 4'h8;

   // ************************************************************
   // Field positions and codes
   // ************************************************************
   localparam int PLC_TABLE_VALUE = 0;  // table_select code, value table
   localparam int PLC_TABLE_ENABLE = 1; // table_select code, enable table
   localparam logic [4:0] PLC_SRC_LAST = 5'h12; // Highest source code

   // Input qualifier codes
   typedef enum logic [2:0] {
      PLC_QUAL_LOW_LEVEL = 3'h0,
      PLC_QUAL_HIGH_LEVEL = 3'h1,
      PLC_QUAL_FALL = 3'h2,
      PLC_QUAL_RISE = 3'h3,
      PLC_QUAL_EITHER_TRANSITION = 3'h4
   } plc_qual_t;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [4:0] PLC_RST_SRC = 5'h00;
   localparam logic [2:0] PLC_RST_QUAL = 3'h1;
   localparam logic [7:0] PLC_RST_TAB = 8'h00;
   localparam logic [7:0] PLC_RST_RDATA = 8'h00;

endpackage

// ==== plc_src_model.sv ====
// Behavioural model of the camera signals feeding the logic cells
`timescale 1ns/1ps
module plc_src_model (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [3:0] io_cmd_i,
   input wire logic [3:0] soft_cmd_i,
   output logic [3:0] io_pin_o,
   output logic [3:0] soft_bit_o,
   output logic cnt_zero_begin_evt_o,
   output logic cnt_one_begin_evt_o,
   output logic cnt_zero_finish_evt_o,
   output logic cnt_one_finish_evt_o,
   output logic expose_begin_evt_o,
   output logic expose_finish_evt_o,
   output logic awaiting_frame_trig_o,
   output logic capture_running_o
);
   logic [7:0] tick_q;

   // ************************************************************
   // Line levels follow commands one edge late, like a synchronizer
   // ************************************************************
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         tick_q <= 8'h00;
         io_pin_o <= 4'h0;
         soft_bit_o <= 4'h0;
      end else begin
         tick_q <= tick_q + 8'h01;
         io_pin_o <= io_cmd_i;
         soft_bit_o <= soft_cmd_i;
      end
   end

   // Events are one-cycle pulses, spread so they never coincide
   assign cnt_zero_begin_evt_o = (tick_q == 8'h10);
   assign cnt_one_begin_evt_o = (tick_q == 8'h30);
   assign cnt_zero_finish_evt_o = (tick_q == 8'h50);
   assign cnt_one_finish_evt_o = (tick_q == 8'h70);
   assign expose_begin_evt_o = (tick_q == 8'h90);
   assign expose_finish_evt_o = (tick_q == 8'hb0);
   assign awaiting_frame_trig_o = tick_q[7];
   assign capture_running_o = tick_q[6];
endmodule // plc_src_model

// ==== test_programmable_lut_logic_cell.sv ====
// Self-checking testbench for the two logic cells
`timescale 1ns/1ps
module test_programmable_lut_logic_cell
   import plc_pkg::*;
;
   logic core_clk_i, resetn_i, reg_wr_i, reg_rd_i, pend_q, pend_st_q;
   logic [3:0] reg_addr_i, io_cmd, soft_cmd, io_pin, soft_bit;
   logic [7:0] reg_wdata_i, reg_rdata_o;
   logic e0b, e1b, e0f, e1f, exb, exf, ftw, cap, c0, c1;
   logic [7:0] exp_q[$];
   logic [1:0] exp_pin_q[$];
   logic [4:0] src_m[2][4];
   logic [2:0] qual_m[2][4];
   logic [7:0] tab_m[2][2];
   int fail_count, checks;

   plc_cells i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .io_pin_i(io_pin), .soft_bit_i(soft_bit),
      .cnt_zero_begin_evt_i(e0b), .cnt_one_begin_evt_i(e1b),
      .cnt_zero_finish_evt_i(e0f), .cnt_one_finish_evt_i(e1f),
      .expose_begin_evt_i(exb), .expose_finish_evt_i(exf),
      .awaiting_frame_trig_i(ftw), .capture_running_i(cap),
      .cell_zero_out_o(c0), .cell_one_out_o(c1));

   plc_src_model i_src (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .io_cmd_i(io_cmd), .soft_cmd_i(soft_cmd), .io_pin_o(io_pin),
      .soft_bit_o(soft_bit), .cnt_zero_begin_evt_o(e0b),
      .cnt_one_begin_evt_o(e1b), .cnt_zero_finish_evt_o(e0f),
      .cnt_one_finish_evt_o(e1f), .expose_begin_evt_o(exb),
      .expose_finish_evt_o(exf), .awaiting_frame_trig_o(ftw),
      .capture_running_o(cap));

   // ************************************************************
   // Bus tasks and checking
   // ************************************************************
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   // Expected data is queued at the strobe, checked by the monitor
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask

   task automatic set_in(input int c, input int i, input logic [4:0] s,
                         input logic [2:0] q);
      wr(PLC_OFS_CELL_SEL, 8'(c));
      wr(PLC_OFS_INPUT_SEL, 8'(i));
      wr(PLC_OFS_INPUT_SRC, {3'h0, s});
      wr(PLC_OFS_INPUT_QUAL, {5'h0, q});
      src_m[c][i] = s;
      qual_m[c][i] = q;
   endtask

   task automatic set_tab(input int c, input int t, input logic [7:0] v);
      wr(PLC_OFS_CELL_SEL, 8'(c));
      wr(PLC_OFS_TABLE_SEL, 8'(t));
      wr(PLC_OFS_TT_WORD, v);
      tab_m[c][t] = v;
   endtask

   task automatic chk_rd(input logic [7:0] e);
      checks++;
      if (reg_rdata_o !== e) begin
         fail_count++;
         $display("Error reg_rdata_o expected %h seen %h", e, reg_rdata_o);
      end
   endtask

   task automatic chk_pin(input logic [1:0] e);
      checks++;
      if ({c1, c0} !== e) begin
         fail_count++;
         $display("Error cell_out_o expected %h seen %h", e, {c1, c0});
      end
   endtask

   // Status read; the two output pins must show the same pair
   task automatic rd_st(input logic [1:0] e);
      exp_pin_q.push_back(e);
      rd(PLC_OFS_STATUS, {6'h00, e});
   endtask

   task automatic tally_and_finish();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge core_clk_i) begin
      if (pend_q === 1'b1) begin
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("Error reg_rdata_o expected none seen %h", reg_rdata_o);
         end else
            chk_rd(exp_q.pop_front());
      end
      if (pend_st_q === 1'b1) begin
         if (exp_pin_q.size() == 0) begin
            fail_count++;
            $display("Error cell_out_o expected none seen %h", {c1, c0});
         end else
            chk_pin(exp_pin_q.pop_front());
      end
      pend_q <= reg_rd_i;
      pend_st_q <= reg_rd_i && reg_addr_i == PLC_OFS_STATUS;
   end

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // Watchdog so a hung sequence still reaches the verdict
   initial begin
      repeat (60000) @(posedge core_clk_i);
      fail_count++;
      $display("Error watchdog expected finish seen timeout");
      tally_and_finish();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      logic [7:0] vt, last;
      logic [2:0] pat, row;
      int r;
      {resetn_i, reg_wr_i, reg_rd_i} = 3'h0;
      {reg_addr_i, io_cmd, soft_cmd} = 12'h000;
      reg_wdata_i = 8'h00;
      fail_count = 0;
      checks = 0;
      void'($urandom(38));
      repeat (12) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      // Every offset after reset, unmapped ones included
      for (int a = 0; a < 16; a++) begin
         if (a == 8)
            rd_st(2'h0);
         else
            rd(a[3:0], (a == 4) ? {5'h0, PLC_RST_QUAL} : 8'h00);
      end
      $display("reset test done");
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 4; i++)
            set_in(c, i, 5'($urandom_range(18)), 3'($urandom_range(4)));
      // Other table selected: input settings must still be the same
      wr(PLC_OFS_TABLE_SEL, 8'h01);
      for (int c = 0; c < 2; c++)
         for (int i = 0; i < 4; i++) begin
            wr(PLC_OFS_CELL_SEL, 8'(c));
            wr(PLC_OFS_INPUT_SEL, 8'(i));
            rd(PLC_OFS_INPUT_SRC, {3'h0, src_m[c][i]});
            rd(PLC_OFS_INPUT_QUAL, {5'h0, qual_m[c][i]});
         end
      rd(PLC_OFS_CELL_SEL, 8'h01);
      rd(PLC_OFS_TABLE_SEL, 8'h01);
      // Upper write bits beyond the source field are dropped
      wr(PLC_OFS_INPUT_SRC, 8'hf2);
      rd(PLC_OFS_INPUT_SRC, 8'h12);
      wr(4'hc, 8'h5a);
      rd(4'hc, 8'h00);
      $display("input setting test done");
      for (int c = 0; c < 2; c++)
         for (int t = 0; t < 2; t++)
            set_tab(c, t, 8'($urandom));
      // Single-row write must leave the other seven bits alone
      for (int c = 0; c < 2; c++)
         for (int t = 0; t < 2; t++) begin
            r = $urandom_range(7);
            wr(PLC_OFS_CELL_SEL, 8'(c));
            wr(PLC_OFS_TABLE_SEL, 8'(t));
            wr(PLC_OFS_ROW_INDEX, 8'(r));
            tab_m[c][t][r] = ~tab_m[c][t][r];
            wr(PLC_OFS_ROW_BIT, {7'h0, tab_m[c][t][r]});
            rd(PLC_OFS_ROW_INDEX, 8'(r));
            rd(PLC_OFS_ROW_BIT, {7'h0, tab_m[c][t][r]});
            rd(PLC_OFS_TT_WORD, tab_m[c][t]);
         end
      $display("table access test done");
      for (int c = 0; c < 2; c++) begin
         set_tab(c, 0, 8'h00);
         set_tab(c, 1, 8'hff);
      end
      // Cell zero: io0, io1 high level, soft bit 0 low level
      set_in(0, 0, 5'd1, 3'd1);
      set_in(0, 1, 5'd2, 3'd1);
      set_in(0, 2, 5'd5, 3'd0);
      vt = 8'($urandom);
      set_tab(0, 0, vt);
      for (int k = 0; k < 8; k++) begin
         pat = 3'($urandom);
         io_cmd <= {2'b00, pat[1:0]};
         soft_cmd <= {3'b000, pat[2]};
         row = {~pat[2], pat[1:0]};
         idle(5);
         rd_st({1'b0, vt[row]});
      end
      last = {8{vt[row]}};
      set_tab(0, 1, 8'h00);
      set_tab(0, 0, ~last);
      io_cmd <= {2'b00, ~pat[1:0]};
      idle(5);
      rd_st({1'b0, last[0]});
      set_tab(0, 0, 8'h00);
      set_tab(0, 1, 8'hff);
      $display("cell function test done");
      // Cell one latches on in0 = io2 under each qualifier
      for (int q = 0; q < 5; q++) begin
         io_cmd <= 4'h4;
         set_tab(1, 0, 8'h00);
         set_tab(1, 1, 8'hff);
         set_in(1, 0, 5'd3, 3'(q));
         set_tab(1, 1, 8'haa);
         set_tab(1, 0, 8'hff);
         idle(4);
         rd_st({q == 1, 1'b0});
         io_cmd <= 4'h0;
         idle(6);
         rd_st({q != 3, 1'b0});
         io_cmd <= 4'h4;
         idle(6);
         rd_st(2'h2);
      end
      $display("qualifier test done");
      // Cell zero loads once on a rise of io0; odd enable rows only
      io_cmd <= 4'h0;
      set_in(0, 0, 5'd1, 3'd3);
      set_tab(0, 1, 8'haa);
      set_tab(0, 0, 8'hff);
      idle(4);
      rd_st(2'h2);
      io_cmd <= 4'h1;
      idle(6);
      rd_st(2'h3);
      $display("edge test done");
      for (int w = 0; w < 20 && exp_q.size() > 0; w++)
         @(posedge core_clk_i);
      if (exp_q.size() > 0 || exp_pin_q.size() > 0) begin
         fail_count++;
         $display("Error exp_q expected empty seen %0d", exp_q.size());
      end
      tally_and_finish();
   end
endmodule // test_programmable_lut_logic_cell
